/* logic/mtor_acc_if.sv */
// carrier between the controller and one thermal accumulator
// assumes: single clock domain, accumulator width 32
interface mtor_acc_if;
	logic step;
	logic clear;
	logic [15:0] load_amps;
	logic [15:0] rated_amps;
	logic [15:0] derate_pct;
	logic [31:0] value;
	logic trip;

	modport ctrl (output step, output clear, output load_amps, output rated_amps,
		output derate_pct, input value, input trip);
	modport acc (input step, input clear, input load_amps, input rated_amps,
		input derate_pct, output value, output trip);
endinterface

/* logic/mtor_accum.sv */
// one thermal accumulator: square-law heating, exponential cooling
// assumes: step is a one-cycle pulse once per control period
module mtor_accum
	import mtor_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// controller side
	mtor_acc_if.acc acc
);
`include "mtor_regs.svh"

	logic [31:0] value_reg;
	logic [31:0] value_next;
	logic [63:0] heat;
	logic [63:0] equil;
	logic [31:0] cool;

	// heat term scaled so a steady current of rated*sqrt(derate/100) settles at the trip level
	always_comb begin
		value_next = value_reg;
		heat = 64'd0;
		equil = 64'd0;
		cool = value_reg >> `MTOR_COOL_SHIFT;
		if (acc.rated_amps != 16'h0000 && acc.derate_pct != 16'h0000) begin
			// one division only, so a small rating cannot round the divisor to zero
			equil = ({48'd0, acc.load_amps} * {48'd0, acc.load_amps} * 64'd10000)
				/ ({48'd0, acc.rated_amps} * {48'd0, acc.rated_amps}
				* {48'd0, acc.derate_pct});
			heat = (equil * {32'd0, `MTOR_TRIP_LEVEL}) >> 12;
			heat = heat / 64'd100;
		end
		if ({32'd0, value_reg} + heat[31:0] - {32'd0, cool} >= {32'd0, `MTOR_TRIP_LEVEL}
			|| heat[63:32] != 32'd0) begin
			value_next = `MTOR_TRIP_LEVEL;
		end else begin
			value_next = value_reg + heat[31:0] - cool;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i || acc.clear) begin
			value_reg <= 32'h0000_0000;
		end else if (acc.step) begin
			value_reg <= value_next;
		end
	end

	assign acc.value = value_reg;
	assign acc.trip = (value_reg >= `MTOR_TRIP_LEVEL);
endmodule

/* logic/mtor_pkg.sv */
// types shared by the motor thermal overload block
// assumes: compiled before every other file of the block
package mtor_pkg;
	typedef enum logic [1:0] {
		MTOR_CURVE_OFF,
		MTOR_CURVE_STD,
		MTOR_CURVE_CT
	} mtor_curve_t;

	typedef enum logic [1:0] {
		MTOR_TH_COOL,
		MTOR_TH_PREALARM,
		MTOR_TH_TRIPPED
	} mtor_state_t;
endpackage

/* logic/mtor_regs.svh */
// constants of the motor thermal overload block
// assumes: included by the mtor_accum and mtor_relay design files, 50 MHz clock
`ifndef MTOR_REGS_SVH
`define MTOR_REGS_SVH

`define MTOR_CLK_HZ 50000000
`define MTOR_PERIOD_US 1000
`define MTOR_PERIOD_CYC ((`MTOR_CLK_HZ / 1000000) * `MTOR_PERIOD_US)
`define MTOR_CUR_MAX 16'd500
`define MTOR_SET_INVALID 16'd9999
`define MTOR_FUNC_SECOND_SEL 8'd3
`define MTOR_FUNC_PREALARM_POS 8'd8
`define MTOR_FUNC_PREALARM_NEG 8'd108
`define MTOR_PREALARM_PCT 32'd85
`define MTOR_TRIP_PCT 32'd100
`define MTOR_SMALL_PCT 32'd85
`define MTOR_CT_MIN_FREQ 16'd600
`define MTOR_LOW_FREQ_KNEE 16'd3000
`define MTOR_ACC_W 32
`define MTOR_TRIP_LEVEL 32'h4000_0000
`define MTOR_COOL_SHIFT 12
`define MTOR_MOTOR_INIT 8'd0

`endif

/* logic/mtor_relay.sv */
// electronic thermal overload relay for a motor drive
// assumes: settings are static words from the parameter store, current in amps,
// frequency in units of 0.01 Hz, clock and reset from the drive control logic
`include "mtor_regs.svh"

// Overview of operation
// - integrate current against rated current, trip
// - rated zero disables motor thermal function
// - second rating 0..500, 9999 invalid
// - second select uses second rating
// - prealarm output at 85 percent
// - overload fault at 100 percent
// - prealarm alone never trips
// - output code 8 high, 108 low
// - input function code 3 selects second
// - fault cleared by power or reset
// - small drives initialise rating to 85 percent
// - listed motor codes pick constant torque
// - constant torque curve from 6 Hz
// - only listed motor codes accepted
// - second motor code 0/1, 9999 keeps first
// - higher pwm shortens transistor protection
// - unselected set integrates at zero amps
// - writes only when read select zero
module mtor_relay
	import mtor_pkg::*;
#(
	parameter int unsigned PERIOD_CYC = `MTOR_PERIOD_CYC,
	parameter int unsigned N_IN = 5,
	parameter int unsigned N_OUT = 6,
	parameter logic [15:0] DRIVE_RATED_AMPS = 16'd5,
	parameter bit SMALL_CAPACITY = 1'b0
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// process values
	input wire logic [15:0] output_current_i,
	input wire logic [15:0] output_freq_i,
	input wire logic [1:0] pwm_frequency_select_i,
	input wire logic [15:0] transistor_rated_amps_i,
	// setting write port
	input wire logic set_write_i,
	input wire logic [2:0] set_index_i,
	input wire logic [15:0] set_data_i,
	input wire logic [7:0] user_group_read_select_i,
	// terminals
	input wire logic [N_IN-1:0] input_terminals_i,
	input wire logic [8*N_IN-1:0] input_function_codes_i,
	input wire logic [8*N_OUT-1:0] output_function_codes_i,
	input wire logic fault_reset_i,
	// status
	output logic [N_OUT-1:0] output_terminals_o,
	output logic thermal_prealarm_out_o,
	output logic prealarm_indication_o,
	output logic motor_overload_fault_o,
	output logic transistor_overload_fault_o,
	output logic second_set_select_o,
	output logic set_refused_o,
	output logic [15:0] rated_current_setting_o,
	output logic [15:0] second_rated_current_setting_o,
	output logic [7:0] applied_motor_code_o,
	output logic [15:0] second_applied_motor_code_o,
	output logic [31:0] thermal_value_o
);

	if (PERIOD_CYC < 1 || N_IN < 1 || N_OUT < 1 || DRIVE_RATED_AMPS > `MTOR_CUR_MAX) begin
		$error("mtor_relay: unsupported parameter values");
	end

	localparam logic [2:0] IDX_RATED = 3'd0;
	localparam logic [2:0] IDX_RATED2 = 3'd1;
	localparam logic [2:0] IDX_MOTOR = 3'd2;
	localparam logic [2:0] IDX_MOTOR2 = 3'd3;
	localparam logic [31:0] PREALARM_LEVEL = 32'(({32'd0, `MTOR_TRIP_LEVEL}
		* 64'(`MTOR_PREALARM_PCT)) / 64'(`MTOR_TRIP_PCT));

	// ----------------------------------------
	// helpers
	// ----------------------------------------

	function automatic logic motor_code_ok(input logic [7:0] c);
		case (c)
			8'd0, 8'd1, 8'd3, 8'd4, 8'd5, 8'd6, 8'd13, 8'd14, 8'd15, 8'd16,
			8'd23, 8'd24, 8'd40, 8'd43, 8'd44, 8'd50, 8'd53, 8'd54: motor_code_ok = 1'b1;
			default: motor_code_ok = 1'b0;
		endcase
	endfunction

	function automatic logic motor_code_ct(input logic [7:0] c);
		case (c)
			8'd1, 8'd13, 8'd14, 8'd15, 8'd16, 8'd50, 8'd53, 8'd54: motor_code_ct = 1'b1;
			default: motor_code_ct = 1'b0;
		endcase
	endfunction

	// derating of allowed current: a standard motor cools worse at low speed
	function automatic logic [15:0] derate(input mtor_curve_t curve, input logic [15:0] f);
		logic [31:0] d;
		d = 32'd100;
		case (curve)
			MTOR_CURVE_STD: begin
				if (f < `MTOR_LOW_FREQ_KNEE) begin
					d = 32'd70 + (32'(f) * 32'd30) / 32'(`MTOR_LOW_FREQ_KNEE);
				end
			end
			// flat curve only from 6 Hz up
			MTOR_CURVE_CT: begin
				if (f < `MTOR_CT_MIN_FREQ) begin
					d = 32'd70 + (32'(f) * 32'd30) / 32'(`MTOR_LOW_FREQ_KNEE);
				end
			end
			default: d = 32'd100;
		endcase
		derate = d[15:0];
	endfunction

	// ----------------------------------------
	// settings
	// ----------------------------------------

	logic [15:0] rated_reg;
	logic [15:0] rated2_reg;
	logic [7:0] motor_reg;
	logic [15:0] motor2_reg;
	logic write_ok;
	logic value_ok;
	logic [31:0] rated_init;

	// initial rating depends on capacity class
	assign rated_init = SMALL_CAPACITY ?
		(32'(DRIVE_RATED_AMPS) * `MTOR_SMALL_PCT) / 32'd100 : 32'(DRIVE_RATED_AMPS);

	always_comb begin
		value_ok = 1'b0;
		case (set_index_i)
			IDX_RATED: value_ok = (set_data_i <= `MTOR_CUR_MAX);
			IDX_RATED2: value_ok = (set_data_i <= `MTOR_CUR_MAX)
				|| (set_data_i == `MTOR_SET_INVALID);
			IDX_MOTOR: value_ok = (set_data_i[15:8] == 8'h00) && motor_code_ok(set_data_i[7:0]);
			IDX_MOTOR2: value_ok = (set_data_i <= 16'h0001) || (set_data_i == `MTOR_SET_INVALID);
			default: value_ok = 1'b0;
		endcase
	end

	assign write_ok = set_write_i && value_ok && (user_group_read_select_i == 8'h00);
	assign set_refused_o = set_write_i && !write_ok;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rated_reg <= rated_init[15:0];
			rated2_reg <= `MTOR_SET_INVALID;
			motor_reg <= `MTOR_MOTOR_INIT;
			motor2_reg <= `MTOR_SET_INVALID;
		end else if (write_ok) begin
			case (set_index_i)
				IDX_RATED: rated_reg <= set_data_i;
				IDX_RATED2: rated2_reg <= set_data_i;
				IDX_MOTOR: motor_reg <= set_data_i[7:0];
				IDX_MOTOR2: motor2_reg <= set_data_i;
				default: rated_reg <= rated_reg;
			endcase
		end
	end

	// ----------------------------------------
	// set selection
	// ----------------------------------------

	logic second_sel;
	logic use_second;
	mtor_curve_t curve1;
	mtor_curve_t curve2;

	always_comb begin
		second_sel = 1'b0;
		for (int i = 0; i < N_IN; i++) begin
			if (input_function_codes_i[8*i +: 8] == `MTOR_FUNC_SECOND_SEL && input_terminals_i[i]) begin
				second_sel = 1'b1;
			end
		end
	end

	// second set valid only with a real rating
	assign use_second = second_sel && (rated2_reg != `MTOR_SET_INVALID);
	assign second_set_select_o = second_sel;

	always_comb begin
		// zero rating switches motor protection off
		if (rated_reg == 16'h0000) begin
			curve1 = MTOR_CURVE_OFF;
		end else if (motor_code_ct(motor_reg)) begin
			curve1 = MTOR_CURVE_CT;
		end else begin
			curve1 = MTOR_CURVE_STD;
		end
		if (rated2_reg == 16'h0000 || rated2_reg == `MTOR_SET_INVALID) begin
			curve2 = MTOR_CURVE_OFF;
		// 9999 falls back to first motor curve
		end else if (motor2_reg == `MTOR_SET_INVALID) begin
			curve2 = motor_code_ct(motor_reg) ? MTOR_CURVE_CT : MTOR_CURVE_STD;
		end else if (motor2_reg == 16'h0001) begin
			curve2 = MTOR_CURVE_CT;
		end else begin
			curve2 = MTOR_CURVE_STD;
		end
	end

	// ----------------------------------------
	// period tick
	// ----------------------------------------

	logic [31:0] tick_cnt_reg;
	logic tick;

	assign tick = (tick_cnt_reg == 32'(PERIOD_CYC - 1));

	always_ff @(posedge clk_i) begin
		if (reset_i || tick) begin
			tick_cnt_reg <= 32'h0000_0000;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
		end
	end

	// ----------------------------------------
	// accumulators
	// ----------------------------------------

	mtor_acc_if acc1 ();
	mtor_acc_if acc2 ();
	mtor_acc_if acct ();

	// idle set integrates zero amps to cool
	assign acc1.step = tick;
	assign acc1.clear = (curve1 == MTOR_CURVE_OFF);
	assign acc1.load_amps = use_second ? 16'h0000 : output_current_i;
	assign acc1.rated_amps = rated_reg;
	assign acc1.derate_pct = derate(curve1, output_freq_i);
	assign acc2.step = tick;
	assign acc2.clear = (curve2 == MTOR_CURVE_OFF);
	assign acc2.load_amps = use_second ? output_current_i : 16'h0000;
	assign acc2.rated_amps = rated2_reg;
	assign acc2.derate_pct = derate(curve2, output_freq_i);

	// higher pwm lowers the transistor allowance
	assign acct.step = tick;
	assign acct.clear = 1'b0;
	assign acct.load_amps = output_current_i;
	assign acct.rated_amps = transistor_rated_amps_i;
	assign acct.derate_pct = 16'd100 - 16'(pwm_frequency_select_i) * 16'd10;

	mtor_accum u_acc1 (.clk_i(clk_i), .reset_i(reset_i), .acc(acc1.acc));
	mtor_accum u_acc2 (.clk_i(clk_i), .reset_i(reset_i), .acc(acc2.acc));
	mtor_accum u_acct (.clk_i(clk_i), .reset_i(reset_i), .acc(acct.acc));

	// ----------------------------------------
	// alarm and fault state
	// ----------------------------------------

	logic [31:0] active_value;
	mtor_state_t state_reg;
	logic tht_reg;

	assign active_value = use_second ? acc2.value : acc1.value;

	// the fault latches; cooling alone never releases it
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_reg <= MTOR_TH_COOL;
		end else begin
			case (state_reg)
				MTOR_TH_COOL, MTOR_TH_PREALARM: begin
					if (active_value >= `MTOR_TRIP_LEVEL) begin
						state_reg <= MTOR_TH_TRIPPED;
					end else if (active_value >= PREALARM_LEVEL) begin
						state_reg <= MTOR_TH_PREALARM;
					end else begin
						state_reg <= MTOR_TH_COOL;
					end
				end
				MTOR_TH_TRIPPED: begin
					// a standing trip cause wins over the reset input
					if (fault_reset_i && active_value < `MTOR_TRIP_LEVEL) begin
						state_reg <= MTOR_TH_COOL;
					end
				end
				default: state_reg <= MTOR_TH_COOL;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			tht_reg <= 1'b0;
		end else if (acct.trip) begin
			tht_reg <= 1'b1;
		end else if (fault_reset_i) begin
			tht_reg <= 1'b0;
		end
	end

	// prealarm is status only, no trip path
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			thermal_prealarm_out_o <= 1'b0;
			prealarm_indication_o <= 1'b0;
			motor_overload_fault_o <= 1'b0;
			transistor_overload_fault_o <= 1'b0;
			thermal_value_o <= 32'h0000_0000;
		end else begin
			thermal_prealarm_out_o <= (active_value >= PREALARM_LEVEL);
			prealarm_indication_o <= (active_value >= PREALARM_LEVEL);
			motor_overload_fault_o <= (state_reg == MTOR_TH_TRIPPED);
			transistor_overload_fault_o <= tht_reg;
			thermal_value_o <= active_value;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			output_terminals_o <= '0;
		end else begin
			for (int j = 0; j < N_OUT; j++) begin
				if (output_function_codes_i[8*j +: 8] == `MTOR_FUNC_PREALARM_POS) begin
					output_terminals_o[j] <= thermal_prealarm_out_o;
				end else if (output_function_codes_i[8*j +: 8] == `MTOR_FUNC_PREALARM_NEG) begin
					output_terminals_o[j] <= !thermal_prealarm_out_o;
				end else begin
					output_terminals_o[j] <= 1'b0;
				end
			end
		end
	end

	assign rated_current_setting_o = rated_reg;
	assign second_rated_current_setting_o = rated2_reg;
	assign applied_motor_code_o = motor_reg;
	assign second_applied_motor_code_o = motor2_reg;
endmodule

/* sim/mtor_relay_monitor.sv */
// assertion checker on the thermal relay top ports
// assumes: bound into mtor_relay, one clock domain, sync reset
`include "mtor_regs.svh"
module mtor_relay_monitor #(
	parameter int unsigned N_OUT = 6
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic set_write_i,
	input wire logic [2:0] set_index_i,
	input wire logic [15:0] set_data_i,
	input wire logic [7:0] user_group_read_select_i,
	input wire logic [8*N_OUT-1:0] output_function_codes_i,
	input wire logic fault_reset_i,
	input wire logic [N_OUT-1:0] output_terminals_o,
	input wire logic thermal_prealarm_out_o,
	input wire logic prealarm_indication_o,
	input wire logic motor_overload_fault_o,
	input wire logic set_refused_o,
	input wire logic [15:0] rated_current_setting_o,
	input wire logic [31:0] thermal_value_o
);
	localparam logic [31:0] TRIP = `MTOR_TRIP_LEVEL;
	// wide product keeps the threshold exact
	localparam logic [31:0] PRE = 32'((64'(TRIP) * `MTOR_PREALARM_PCT) / `MTOR_TRIP_PCT);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// -------
	// sequences
	// -------
	sequence s_rated_wr;
		set_write_i && set_index_i == 3'h0 && user_group_read_select_i == 8'h00;
	endsequence
	// terminals hold their reset value 0 until the first edge after reset
	sequence s_settled;
		!$past(reset_i) && !$past(reset_i, 2);
	endsequence
	a_rated_take:
	assert property ((s_rated_wr ##0 set_data_i <= `MTOR_CUR_MAX) |->
		!set_refused_o ##1 rated_current_setting_o == $past(set_data_i))
	else $error("rated write not taken");
	a_rated_range:
	assert property ((s_rated_wr ##0 set_data_i > `MTOR_CUR_MAX) |->
		set_refused_o ##1 $stable(rated_current_setting_o))
	else $error("rated out of range accepted");
	a_write_lock:
	assert property (set_write_i && user_group_read_select_i != 8'h00 |->
		set_refused_o ##1 $stable(rated_current_setting_o))
	else $error("write accepted while locked");
	a_pre_mirror:
	assert property (prealarm_indication_o == thermal_prealarm_out_o)
	else $error("indication differs from prealarm");
	a_pre_level:
	assert property ($rose(thermal_prealarm_out_o) |->
		thermal_value_o >= PRE || $past(thermal_value_o) >= PRE)
	else $error("prealarm below level");
	a_fault_hold:
	assert property (motor_overload_fault_o && !fault_reset_i && !$past(fault_reset_i)
		|=> motor_overload_fault_o)
	else $error("fault dropped without reset");
	a_fault_cause:
	assert property ($rose(motor_overload_fault_o) |->
		$past(thermal_value_o) == TRIP || $past(thermal_value_o, 2) == TRIP)
	else $error("fault without trip level");
	a_out_pos:
	assert property ((s_settled ##0 output_function_codes_i[7:0] == 8'h08) |->
		output_terminals_o[0] == $past(thermal_prealarm_out_o))
	else $error("positive terminal wrong");
	a_out_neg:
	assert property ((s_settled ##0 output_function_codes_i[15:8] == 8'h6c) |->
		output_terminals_o[1] != $past(thermal_prealarm_out_o))
	else $error("negative terminal wrong");
endmodule

bind mtor_relay mtor_relay_monitor #(.N_OUT(N_OUT)) u_mon (
	.clk_i(clk_i), .reset_i(reset_i), .set_write_i(set_write_i),
	.set_index_i(set_index_i), .set_data_i(set_data_i),
	.user_group_read_select_i(user_group_read_select_i),
	.output_function_codes_i(output_function_codes_i), .fault_reset_i(fault_reset_i),
	.output_terminals_o(output_terminals_o), .thermal_prealarm_out_o(thermal_prealarm_out_o),
	.prealarm_indication_o(prealarm_indication_o),
	.motor_overload_fault_o(motor_overload_fault_o), .set_refused_o(set_refused_o),
	.rated_current_setting_o(rated_current_setting_o), .thermal_value_o(thermal_value_o)
);

/* sim/tb_top.sv */
// self-checking bench for the thermal overload relay
// assumes: short control period of 4 cycles, 50 MHz clock
`include "mtor_regs.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 0, reset_i = 1, wr_i = 0, frst = 0;
	logic [15:0] cur = 0, data = 0;
	logic [2:0] idx = 0;
	logic [7:0] ugrs = 0;
	logic [4:0] in_t = 0;
	logic [39:0] in_codes = 0;
	logic [47:0] out_codes = 48'h0000_0000_6c08;
	logic [5:0] out_t;
	logic pre, ind, flt, refd, sel, tflt;
	logic [1:0] pwm = 0;
	logic [15:0] trat = 16'h3e8;
	logic [15:0] rated, rated2, mcode2;
	logic [7:0] mcode;
	logic [31:0] tval;
	logic [15:0] mdl [8] = '{16'h14, 16'd9999, 16'h0, 16'd9999, 0, 0, 0, 0};
	int err_total = 0, checked = 0, wcnt = 0;
	mtor_relay #(.PERIOD_CYC(4), .DRIVE_RATED_AMPS(16'h14)) dut (
		.clk_i(clk_i), .reset_i(reset_i), .output_current_i(cur),
		.output_freq_i(16'h1770), .pwm_frequency_select_i(pwm),
		.transistor_rated_amps_i(trat), .set_write_i(wr_i), .set_index_i(idx),
		.set_data_i(data), .user_group_read_select_i(ugrs), .input_terminals_i(in_t),
		.input_function_codes_i(in_codes), .output_function_codes_i(out_codes),
		.fault_reset_i(frst), .output_terminals_o(out_t), .thermal_prealarm_out_o(pre),
		.prealarm_indication_o(ind), .motor_overload_fault_o(flt),
		.transistor_overload_fault_o(tflt), .second_set_select_o(sel), .set_refused_o(refd),
		.rated_current_setting_o(rated), .second_rated_current_setting_o(rated2),
		.applied_motor_code_o(mcode), .second_applied_motor_code_o(mcode2),
		.thermal_value_o(tval));
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	// -------
	// tasks
	// -------
	task give_verdict;
		$display("errors %0d checks %0d", err_total, checked);
		if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(string nm, logic [31:0] exp, logic [31:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task tick(int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	function logic [15:0] get(int i);
		case (i)
			0: return rated;
			1: return rated2;
			2: return {8'h00, mcode};
			3: return mcode2;
			default: return 16'h0;
		endcase
	endfunction
	// one write, refusal seen in the strobe cycle, setting one cycle later
	task wrc(logic [2:0] i, logic [15:0] d, logic r);
		tick(1);
		idx = i;
		data = d;
		wr_i = 1;
		#1 chk("refused", r, refd);
		tick(1);
		wr_i = 0;
		if (!r) mdl[i] = d;
		chk("setting", mdl[i], get(i));
	endtask
	function logic pick(int k);
		return k == 0 ? pre : (k == 1 ? flt : tflt);
	endfunction
	task wt(int k, logic v, int n);
		int c;
		c = 0;
		while (pick(k) !== v && c < n) begin
			tick(1);
			c++;
		end
		wcnt = c;
		if (pick(k) !== v) begin
			err_total++;
			$display("[FAIL] wait %0d exp %b got %b", k, v, pick(k));
			give_verdict();
		end
	endtask
	// -------
	// sequence
	// -------
	initial begin
		int ok[] = '{0, 1, 3, 4, 5, 6, 13, 14, 15, 16, 23, 24, 40, 43, 44, 50, 53, 54};
		int bad[] = '{2, 7, 12, 17, 55, 9999};
		int t_lo;
		tick(16);
		reset_i = 0;
		tick(1);
		for (int i = 0; i < 4; i++) chk("reset setting", mdl[i], get(i));
		chk("reset fault", 0, flt);
		foreach (ok[i]) wrc(3'h2, 16'(ok[i]), 0);
		foreach (bad[i]) wrc(3'h2, 16'(bad[i]), 1);
		wrc(3'h3, 16'h1, 0);
		wrc(3'h3, 16'h2, 1);
		wrc(3'h3, 16'd9999, 0);
		wrc(3'h1, 16'h1f5, 1);
		wrc(3'h1, 16'h1f4, 0);
		wrc(3'h0, 16'h1f5, 1);
		wrc(3'h0, 16'h16, 0); // a 20 A motor on a 60 Hz base is set to 22 A
		wrc(3'h7, 16'h0, 1);
		ugrs = 8'h01;
		wrc(3'h0, 16'h64, 1);
		ugrs = 8'h00;
		wrc(3'h0, 16'ha, 0);
		cur = 16'h14;
		wt(0, 1, 20000);
		chk("fault at prealarm", 0, flt);
		chk("indication", 1, ind);
		tick(1);
		chk("term code 8", 1, out_t[0]);
		chk("term code 108", 0, out_t[1]);
		wt(1, 1, 20000);
		chk("saturated", `MTOR_TRIP_LEVEL, tval);
		cur = 0;
		tick(20);
		chk("fault latched", 1, flt);
		frst = 1;
		tick(10);
		frst = 0;
		tick(1);
		chk("fault cleared", 0, flt);
		wt(0, 0, 20000);
		tick(1);
		chk("term code 108 low", 1, out_t[1]);
		in_codes[7:0] = 8'h03;
		in_t[0] = 1;
		tick(1);
		chk("second select", 1, sel);
		// second rating is 500 A, so the load must be far above the first one
		cur = 16'h3e8;
		wt(0, 1, 20000);
		cur = 0;
		in_t[0] = 0;
		wrc(3'h0, 16'h0, 0);
		cur = 16'h14;
		tick(100);
		chk("disabled value", 0, tval);
		wrc(3'h1, 16'd9999, 0);
		in_t[0] = 1;
		tick(100);
		chk("invalid second", 0, tval);
		// transistor trip time at the lowest and the highest pwm select
		for (int p = 0; p < 4; p += 3) begin
			cur = 0;
			pwm = 2'(p);
			reset_i = 1;
			tick(2);
			reset_i = 0;
			tick(1);
			chk("transistor fault after reset", 0, tflt);
			trat = 16'ha;
			cur = 16'h14;
			wt(2, 1, 20000);
			if (p == 0) begin
				t_lo = wcnt;
			end else begin
				chk("pwm shortens trip", 1, wcnt < t_lo);
			end
		end
		give_verdict();
	end
endmodule
